// ===== sscc_sync_ctrl.sv
// Purpose: Sync source selection, sync outputs, coast, clamp, seek and power-down control
// Assumes: Sync pins are asynchronous; register port and pixelTick are on clock
// Notes on behaviour
// R01: One bit sets line and green sync polarity
// R02: Line source auto unless override set
// R03: Select bit: 0 dedicated, 1 green sync
// R04: Active line status follows detect table
// R05: Frame output inverted when bit is 0
// R06: Frame source override with select bit
// R07: Clamp internal from trailing edge, or pin
// R08: Clamp pin polarity bit, 1 active low
// R09: Coast from pin or active frame sync
// R10: Coast polarity automatic or user set
// R11: Coast masks line edges to clock generator
// R12: Seek mode allowed only when bit set
// R13: Power-down tristates sync, clock, data outputs
// R14: Five-bit slicer threshold, reset code 15
// R15: Red and blue clamp ground or midscale
// R16: Separator toggles after threshold 5 MHz ticks
// R17: Software sets threshold above line pulse
// R18: Pre-coast starts lines before frame sync
// R19: Post-coast extends lines after frame sync
// R20: Line detect ignores idle or constant input
// R21: Green sync detect shows green activity
// R22: Frame detect ignores constant level input
// R23: Inactive after timeout on 5 MHz ticks
`default_nettype none
module sscc_sync_ctrl #(
    parameter int ACT_TIMEOUT = sscc_pkg::ACT_TIMEOUT_TICKS,
    parameter int TICK_DIV = sscc_pkg::SEP_TICK_DIV
) (
    input wire logic clock,
    input wire logic reset_n,
    input wire logic hsyncPin,
    input wire logic sogPin,
    input wire logic vsyncPin,
    input wire logic coastPin,
    input wire logic clampPin,
    input wire logic pixelTick,
    input wire logic [7:0] clampPlacement,
    input wire logic [7:0] clampDuration,
    input wire logic [7:0] regAddr,
    input wire logic [7:0] regWrData,
    input wire logic regWrEn,
    input wire logic regRdEn,
    output logic [7:0] regRdData_ff,
    output logic lineSyncOut_ff,
    output logic greenSyncOut_ff,
    output logic frameSyncOut_ff,
    output logic outputEnable_ff,
    output logic coastActive_ff,
    output logic pllHsyncEdge_ff,
    output logic clampActive_ff,
    output logic clampRedMid_ff,
    output logic clampBlueMid_ff,
    output logic [4:0] sogThreshold_ff,
    output logic seekMode_ff
);
    if (ACT_TIMEOUT < 2 || ACT_TIMEOUT > 1023 || TICK_DIV < 2 || TICK_DIV > 63) begin : g_bad_param
        $error("ACT_TIMEOUT or TICK_DIV out of range");
    end
    localparam logic [9:0] TIMEOUT_W = 10'(ACT_TIMEOUT);
    localparam logic [5:0] DIV_LAST = 6'(TICK_DIV - 1);

    typedef struct packed {
        logic [4:0] s1;
        logic [4:0] s2;
        logic [3:0] prev;
        logic [5:0] div;
        logic [3:0][9:0] idle;
        logic [3:0][9:0] run;
        logic [3:0][9:0] hiLen;
        logic [3:0][9:0] loLen;
        logic [7:0] r0E;
        logic [7:0] r0F;
        logic [7:0] r10;
        logic [7:0] r11;
        logic [7:0] r12;
        logic [7:0] r13;
        logic [7:0] sepCnt;
        logic sepOut;
        logic hsNormPrev;
        logic vsNormPrev;
        logic [10:0] lineCnt;
        logic [10:0] frameLines;
        logic [7:0] postCnt;
        logic [7:0] clampWait;
        logic [7:0] clampRun;
        logic [7:0] rdData;
        logic lineOut;
        logic greenOut;
        logic frameOut;
        logic outEn;
        logic coast;
        logic pllEdge;
        logic clampAct;
        logic seek;
    } sscc_state_t;

    sscc_state_t st_ff;
    sscc_state_t nxt_st;

    logic tick;
    logic [3:0] det, polHigh, edgeSeen;
    logic active_line_sync_status, active_frame_sync_status, hsPolHigh, hsNorm, sogNorm, vsNorm, preCoast, coastNow;
    logic [7:0] status;

    always_comb begin
        nxt_st = st_ff;
        nxt_st.s1 = {clampPin, coastPin, vsyncPin, sogPin, hsyncPin};
        nxt_st.s2 = st_ff.s1;
        nxt_st.prev = st_ff.s2[3:0];
        tick = (st_ff.div == DIV_LAST);
        nxt_st.div = tick ? 6'h00 : st_ff.div + 6'h01;

        // Per input activity and polarity measurement on the 5 MHz tick
        for (int i = 0; i < 4; i++) begin
            edgeSeen[i] = st_ff.s2[i] ^ st_ff.prev[i];
            if (tick && st_ff.idle[i] < TIMEOUT_W) begin
                nxt_st.idle[i] = st_ff.idle[i] + 10'h001; // [R23]
            end
            if (tick && st_ff.run[i] != 10'h3FF) begin
                nxt_st.run[i] = st_ff.run[i] + 10'h001;
            end
            if (edgeSeen[i]) begin
                nxt_st.idle[i] = 10'h000;
                nxt_st.run[i] = 10'h000;
                if (st_ff.prev[i]) begin
                    nxt_st.hiLen[i] = st_ff.run[i];
                end else begin
                    nxt_st.loLen[i] = st_ff.run[i];
                end
            end
            det[i] = st_ff.idle[i] < TIMEOUT_W; // [R20] [R21] [R22] [R23]
            polHigh[i] = st_ff.hiLen[i] < st_ff.loLen[i];
        end

        // Line sync source choice
        if (st_ff.r0E[sscc_pkg::B_HS_SEL_OVR] || det[sscc_pkg::IN_HS] == det[sscc_pkg::IN_SOG]) begin
            active_line_sync_status = st_ff.r0E[sscc_pkg::B_HS_SEL]; // [R02] [R03] [R04]
        end else begin
            active_line_sync_status = det[sscc_pkg::IN_SOG]; // [R04]
        end
        hsPolHigh = st_ff.r0E[sscc_pkg::B_HS_POL_OVR] ? st_ff.r0E[sscc_pkg::B_HS_POL] : polHigh[active_line_sync_status ? 1 : 0];
        sogNorm = st_ff.s2[sscc_pkg::IN_SOG] ^ ~polHigh[sscc_pkg::IN_SOG];
        hsNorm = active_line_sync_status ? sogNorm : (st_ff.s2[sscc_pkg::IN_HS] ^ ~hsPolHigh);
        nxt_st.hsNormPrev = hsNorm;

        // Sync separator filters line pulses out of the composite signal
        if (hsNorm == st_ff.sepOut) begin
            nxt_st.sepCnt = 8'h00;
        end else if (tick) begin
            if (st_ff.sepCnt + 8'h01 >= st_ff.r11 || st_ff.sepCnt == 8'hFF) begin
                nxt_st.sepOut = ~st_ff.sepOut; // [R16]
                nxt_st.sepCnt = 8'h00;
            end else begin
                nxt_st.sepCnt = st_ff.sepCnt + 8'h01;
            end
        end

        // Frame sync source choice
        active_frame_sync_status = st_ff.r0E[sscc_pkg::B_VS_SEL_OVR] ? st_ff.r0E[sscc_pkg::B_VS_SEL] : ~det[sscc_pkg::IN_VS]; // [R06]
        vsNorm = active_frame_sync_status ? st_ff.sepOut : (st_ff.s2[sscc_pkg::IN_VS] ^ ~polHigh[sscc_pkg::IN_VS]);
        nxt_st.vsNormPrev = vsNorm;

        // Line counting for coast extension
        if (vsNorm && !st_ff.vsNormPrev) begin
            nxt_st.frameLines = st_ff.lineCnt;
            nxt_st.lineCnt = 11'h000;
        end else if (hsNorm && !st_ff.hsNormPrev && st_ff.lineCnt != 11'h7FF) begin
            nxt_st.lineCnt = st_ff.lineCnt + 11'h001;
        end
        preCoast = !vsNorm && st_ff.r12 != 8'h00
            && ({1'b0, st_ff.lineCnt} + {4'h0, st_ff.r12}) >= {1'b0, st_ff.frameLines}; // [R18]
        if (!vsNorm && st_ff.vsNormPrev) begin
            nxt_st.postCnt = st_ff.r13; // [R19]
        end else if (hsNorm && !st_ff.hsNormPrev && st_ff.postCnt != 8'h00) begin
            nxt_st.postCnt = st_ff.postCnt - 8'h01; // [R19]
        end

        // Coast source and polarity
        if (st_ff.r0F[sscc_pkg::B_COAST_SRC]) begin
            coastNow = vsNorm || preCoast || st_ff.postCnt != 8'h00; // [R09]
        end else if (st_ff.r0F[sscc_pkg::B_COAST_POL_OVR]) begin
            coastNow = st_ff.s2[sscc_pkg::IN_COAST] == st_ff.r0F[sscc_pkg::B_COAST_POL]; // [R10]
        end else begin
            coastNow = st_ff.s2[sscc_pkg::IN_COAST] == polHigh[sscc_pkg::IN_COAST]; // [R10]
        end
        nxt_st.coast = coastNow;
        nxt_st.pllEdge = hsNorm && !st_ff.hsNormPrev && !coastNow; // [R11]

        // Clamp timing, internal counters run on pixel periods
        if (!hsNorm && st_ff.hsNormPrev) begin
            nxt_st.clampWait = clampPlacement;
            nxt_st.clampRun = 8'h00;
        end else if (pixelTick) begin
            if (st_ff.clampWait != 8'h00) begin
                nxt_st.clampWait = st_ff.clampWait - 8'h01;
                if (st_ff.clampWait == 8'h01) begin
                    nxt_st.clampRun = clampDuration;
                end
            end else if (st_ff.clampRun != 8'h00) begin
                nxt_st.clampRun = st_ff.clampRun - 8'h01;
            end
        end
        if (st_ff.r0F[sscc_pkg::B_CLAMP_SRC]) begin
            nxt_st.clampAct = st_ff.s2[4] ^ st_ff.r0F[sscc_pkg::B_CLAMP_POL]; // [R07] [R08]
        end else begin
            nxt_st.clampAct = st_ff.clampRun != 8'h00; // [R07]
        end

        nxt_st.lineOut = hsNorm ^ st_ff.r0E[sscc_pkg::B_HS_OUT_POL]; // [R01]
        nxt_st.greenOut = sogNorm ^ st_ff.r0E[sscc_pkg::B_HS_OUT_POL]; // [R01]
        nxt_st.frameOut = st_ff.r0E[sscc_pkg::B_VS_OUT_INV] ? vsNorm : ~vsNorm; // [R05]
        nxt_st.outEn = st_ff.r0F[sscc_pkg::B_POWER_NORMAL]; // [R13]
        nxt_st.seek = st_ff.r0F[sscc_pkg::B_SEEK_ALLOW]
            && !det[sscc_pkg::IN_HS] && !det[sscc_pkg::IN_SOG] && !det[sscc_pkg::IN_VS]; // [R12]

        status = {det[sscc_pkg::IN_HS], active_line_sync_status, hsPolHigh, det[sscc_pkg::IN_VS], active_frame_sync_status,
                  ~polHigh[sscc_pkg::IN_VS], det[sscc_pkg::IN_SOG], polHigh[sscc_pkg::IN_COAST]};

        // Register port
        if (regWrEn) begin
            unique case (regAddr)
                sscc_pkg::ADDR_SYNC_SEL_POL: nxt_st.r0E = regWrData;
                sscc_pkg::ADDR_CLAMP_COAST_PWR: nxt_st.r0F = {regWrData[7:1], 1'b0};
                sscc_pkg::ADDR_SLICER_CLAMP_SEL: nxt_st.r10 = {regWrData[7:1], 1'b0};
                sscc_pkg::ADDR_SEP_THRESHOLD: nxt_st.r11 = regWrData;
                sscc_pkg::ADDR_COAST_LEAD: nxt_st.r12 = regWrData;
                sscc_pkg::ADDR_COAST_TRAIL: nxt_st.r13 = regWrData;
                default: nxt_st.r0E = st_ff.r0E;
            endcase
        end
        if (regRdEn) begin
            unique case (regAddr)
                sscc_pkg::ADDR_SYNC_SEL_POL: nxt_st.rdData = st_ff.r0E;
                sscc_pkg::ADDR_CLAMP_COAST_PWR: nxt_st.rdData = st_ff.r0F;
                sscc_pkg::ADDR_SLICER_CLAMP_SEL: nxt_st.rdData = st_ff.r10;
                sscc_pkg::ADDR_SEP_THRESHOLD: nxt_st.rdData = st_ff.r11;
                sscc_pkg::ADDR_COAST_LEAD: nxt_st.rdData = st_ff.r12;
                sscc_pkg::ADDR_COAST_TRAIL: nxt_st.rdData = st_ff.r13;
                sscc_pkg::ADDR_SYNC_STATUS: nxt_st.rdData = status;
                default: nxt_st.rdData = 8'h00;
            endcase
        end
    end

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            st_ff <= '0;
            st_ff.idle <= {4{TIMEOUT_W}};
            st_ff.r0E <= sscc_pkg::RST_SYNC_SEL_POL;
            st_ff.r0F <= sscc_pkg::RST_CLAMP_COAST_PWR;
            st_ff.r10 <= sscc_pkg::RST_SLICER_CLAMP_SEL; // [R14] [R15]
            st_ff.r11 <= sscc_pkg::RST_SEP_THRESHOLD;
            st_ff.r12 <= sscc_pkg::RST_COAST_LEAD;
            st_ff.r13 <= sscc_pkg::RST_COAST_TRAIL;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign regRdData_ff = st_ff.rdData;
    assign lineSyncOut_ff = st_ff.lineOut;
    assign greenSyncOut_ff = st_ff.greenOut;
    assign frameSyncOut_ff = st_ff.frameOut;
    assign outputEnable_ff = st_ff.outEn;
    assign coastActive_ff = st_ff.coast;
    assign pllHsyncEdge_ff = st_ff.pllEdge;
    assign clampActive_ff = st_ff.clampAct;
    assign clampRedMid_ff = st_ff.r10[sscc_pkg::B_RED_MID]; // [R15]
    assign clampBlueMid_ff = st_ff.r10[sscc_pkg::B_BLUE_MID]; // [R15]
    assign sogThreshold_ff = st_ff.r10[7:sscc_pkg::B_SLICER_LSB]; // [R14]
    assign seekMode_ff = st_ff.seek;

    property p_line_pol;
        @(posedge clock) disable iff (!reset_n)
        reset_n |=> lineSyncOut_ff == ($past(hsNorm) ^ $past(st_ff.r0E[sscc_pkg::B_HS_OUT_POL]));
    endproperty
    a_line_pol: assert property (p_line_pol) else $error("line sync polarity wrong"); // [R01]

    property p_ahs_override;
        @(posedge clock) disable iff (!reset_n)
        st_ff.r0E[sscc_pkg::B_HS_SEL_OVR] |-> active_line_sync_status == st_ff.r0E[sscc_pkg::B_HS_SEL];
    endproperty
    a_ahs_override: assert property (p_ahs_override) else $error("override line source ignored"); // [R02]

    property p_ahs_auto;
        @(posedge clock) disable iff (!reset_n)
        !st_ff.r0E[sscc_pkg::B_HS_SEL_OVR] && (det[sscc_pkg::IN_HS] ^ det[sscc_pkg::IN_SOG])
            |-> active_line_sync_status == det[sscc_pkg::IN_SOG];
    endproperty
    a_ahs_auto: assert property (p_ahs_auto) else $error("auto line source wrong"); // [R04]

    property p_avs;
        @(posedge clock) disable iff (!reset_n)
        st_ff.r0E[sscc_pkg::B_VS_SEL_OVR] |-> active_frame_sync_status == st_ff.r0E[sscc_pkg::B_VS_SEL];
    endproperty
    a_avs: assert property (p_avs) else $error("frame source override ignored"); // [R06]

    property p_clamp_ext;
        @(posedge clock) disable iff (!reset_n)
        st_ff.r0F[sscc_pkg::B_CLAMP_SRC] && st_ff.r0F[sscc_pkg::B_CLAMP_POL] && !st_ff.s2[4]
            && $stable(st_ff.r0F) |=> clampActive_ff;
    endproperty
    a_clamp_ext: assert property (p_clamp_ext) else $error("external clamp low not clamping"); // [R08]

    property p_coast_mask;
        @(posedge clock) disable iff (!reset_n)
        pllHsyncEdge_ff |-> !coastActive_ff;
    endproperty
    a_coast_mask: assert property (p_coast_mask) else $error("line edge passed during coast"); // [R11]

    property p_seek;
        @(posedge clock) disable iff (!reset_n)
        seekMode_ff |-> $past(st_ff.r0F[sscc_pkg::B_SEEK_ALLOW]) && !$past(det[sscc_pkg::IN_HS]);
    endproperty
    a_seek: assert property (p_seek) else $error("seek mode entered while disallowed"); // [R12]

    property p_power;
        @(posedge clock) disable iff (!reset_n)
        !st_ff.r0F[sscc_pkg::B_POWER_NORMAL] |=> !outputEnable_ff;
    endproperty
    a_power: assert property (p_power) else $error("outputs driven in power-down"); // [R13]

    property p_sep;
        @(posedge clock) disable iff (!reset_n)
        $changed(st_ff.sepOut) |-> $past(tick) && ($past(st_ff.sepCnt) + 8'h01 >= $past(st_ff.r11)
            || $past(st_ff.sepCnt) == 8'hFF);
    endproperty
    a_sep: assert property (p_sep) else $error("separator toggled before threshold"); // [R16]

    property p_idle;
        @(posedge clock) disable iff (!reset_n)
        st_ff.idle[sscc_pkg::IN_HS] == TIMEOUT_W |-> !det[sscc_pkg::IN_HS];
    endproperty
    a_idle: assert property (p_idle) else $error("idle line input reported active"); // [R20]
endmodule
`default_nettype wire

// ===== sscc_pkg.sv
// Purpose: Constants for the sync source select, coast and clamp control block
// Assumes: 200 MHz system clock, 8-bit register port fed by the serial port logic
// Notes: Register offsets are byte addresses on the internal register port
`default_nettype none
package sscc_pkg;
    // Register offsets
    localparam logic [7:0] ADDR_SYNC_SEL_POL = 8'h0E;
    localparam logic [7:0] ADDR_CLAMP_COAST_PWR = 8'h0F;
    localparam logic [7:0] ADDR_SLICER_CLAMP_SEL = 8'h10;
    localparam logic [7:0] ADDR_SEP_THRESHOLD = 8'h11;
    localparam logic [7:0] ADDR_COAST_LEAD = 8'h12;
    localparam logic [7:0] ADDR_COAST_TRAIL = 8'h13;
    localparam logic [7:0] ADDR_SYNC_STATUS = 8'h14;
    // Reset values
    localparam logic [7:0] RST_SYNC_SEL_POL = 8'h40;
    localparam logic [7:0] RST_CLAMP_COAST_PWR = 8'h4E;
    localparam logic [7:0] RST_SLICER_CLAMP_SEL = 8'h78;
    localparam logic [7:0] RST_SEP_THRESHOLD = 8'h20;
    localparam logic [7:0] RST_COAST_LEAD = 8'h00;
    localparam logic [7:0] RST_COAST_TRAIL = 8'h00;
    // Field positions, sync select and polarity register
    localparam int B_HS_POL_OVR = 7;
    localparam int B_HS_POL = 6;
    localparam int B_HS_OUT_POL = 5;
    localparam int B_HS_SEL_OVR = 4;
    localparam int B_HS_SEL = 3;
    localparam int B_VS_OUT_INV = 2;
    localparam int B_VS_SEL_OVR = 1;
    localparam int B_VS_SEL = 0;
    // Field positions, clamp, coast and power register
    localparam int B_CLAMP_SRC = 7;
    localparam int B_CLAMP_POL = 6;
    localparam int B_COAST_SRC = 5;
    localparam int B_COAST_POL_OVR = 4;
    localparam int B_COAST_POL = 3;
    localparam int B_SEEK_ALLOW = 2;
    localparam int B_POWER_NORMAL = 1;
    // Field positions, slicer and clamp select register
    localparam int B_SLICER_LSB = 3;
    localparam int B_RED_MID = 2;
    localparam int B_BLUE_MID = 1;
    // Status bits
    localparam int B_ST_HS_DET = 7;
    localparam int B_ST_AHS = 6;
    localparam int B_ST_HS_POL = 5;
    localparam int B_ST_VS_DET = 4;
    localparam int B_ST_AVS = 3;
    localparam int B_ST_VS_POL = 2;
    localparam int B_ST_SOG_DET = 1;
    localparam int B_ST_COAST_POL = 0;
    // Monitored input indices
    localparam int IN_HS = 0;
    localparam int IN_SOG = 1;
    localparam int IN_VS = 2;
    localparam int IN_COAST = 3;
    // Timing
    localparam int CLK_PERIOD_NS = 5;
    localparam int SEP_CLK_PERIOD_NS = 200;
    localparam int SEP_TICK_DIV = SEP_CLK_PERIOD_NS / CLK_PERIOD_NS;
    localparam int ACT_TIMEOUT_US = 100;
    localparam int ACT_TIMEOUT_TICKS = ACT_TIMEOUT_US * 1000 / SEP_CLK_PERIOD_NS;
endpackage
`default_nettype wire

// ===== sscc_sync_source.sv
// Purpose: Graphics source model driving line, green and frame sync pins
// Assumes: Pulses are active high; a disabled source holds its pin low
// Notes: Pins change just after the clock edge because counters update there
`default_nettype none
module sscc_sync_source #(
    parameter int LINE_PERIOD = 20,
    parameter int LINE_WIDTH = 3,
    parameter int FRAME_PERIOD = 64,
    parameter int FRAME_WIDTH = 16
) (
    input wire logic clock,
    input wire logic lineOn,
    input wire logic greenOn,
    input wire logic frameOn,
    output logic hsyncPin,
    output logic sogPin,
    output logic vsyncPin
);
    timeunit 1ns;
    timeprecision 1ps;
    int lineCnt = 0;
    int frameCnt = 0;

    always @(posedge clock) begin
        lineCnt <= (lineCnt == LINE_PERIOD - 1) ? 0 : lineCnt + 1;
        frameCnt <= (frameCnt == FRAME_PERIOD - 1) ? 0 : frameCnt + 1;
    end

    // Line pulse kept far shorter than the separator threshold count
    assign hsyncPin = lineOn && (lineCnt < LINE_WIDTH);
    assign sogPin = greenOn && (lineCnt < LINE_WIDTH);
    assign vsyncPin = frameOn && (frameCnt < FRAME_WIDTH);
endmodule
`default_nettype wire

// ===== sync_source_select_coast_clamp_ctrl_tb.sv
// Purpose: Self-checking bench for the sync select, coast and clamp block
// Assumes: Short detect timeout and tick divider to keep the run brief
// Notes: Status reads after each input change wait longer than the inactivity timeout
`default_nettype none
module sync_source_select_coast_clamp_ctrl_tb;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int SETTLE = 300;
    logic clock = 1'b0;
    logic reset_n = 1'b0;
    logic lineOn = 1'b0;
    logic greenOn = 1'b0;
    logic frameOn = 1'b0;
    logic coastPin = 1'b0;
    logic clampPin = 1'b0;
    logic pixelTick = 1'b0;
    logic [1:0] tickDiv = 2'h0;
    logic [7:0] regAddr = 8'h00;
    logic [7:0] regWrData = 8'h00;
    logic regWrEn = 1'b0;
    logic regRdEn = 1'b0;
    logic hsyncPin, sogPin, vsyncPin, lineOut, greenOut, frameOut, outEn, coastAct, pllEdge;
    logic clampAct, redMid, blueMid, seek;
    logic [7:0] rdData;
    logic [4:0] sogThr;
    int n_errors = 0;
    int checks_done = 0;
    int edgeCount = 0;
    int clampCount = 0;
    int coastCount = 0;

    always #2.5 clock = ~clock;
    always @(posedge clock) begin
        tickDiv <= tickDiv + 2'h1;
        pixelTick <= (tickDiv == 2'h3);
        if (pllEdge === 1'b1) edgeCount <= edgeCount + 1;
        if (clampAct === 1'b1) clampCount <= clampCount + 1;
        if (coastAct === 1'b1) coastCount <= coastCount + 1;
    end

    sscc_sync_source src (.clock(clock), .lineOn(lineOn), .greenOn(greenOn), .frameOn(frameOn),
        .hsyncPin(hsyncPin), .sogPin(sogPin), .vsyncPin(vsyncPin));

    sscc_sync_ctrl #(.ACT_TIMEOUT(20), .TICK_DIV(4)) dut (.clock(clock), .reset_n(reset_n),
        .hsyncPin(hsyncPin), .sogPin(sogPin), .vsyncPin(vsyncPin), .coastPin(coastPin),
        .clampPin(clampPin), .pixelTick(pixelTick), .clampPlacement(8'h04), .clampDuration(8'h08),
        .regAddr(regAddr), .regWrData(regWrData), .regWrEn(regWrEn), .regRdEn(regRdEn),
        .regRdData_ff(rdData), .lineSyncOut_ff(lineOut), .greenSyncOut_ff(greenOut),
        .frameSyncOut_ff(frameOut), .outputEnable_ff(outEn), .coastActive_ff(coastAct),
        .pllHsyncEdge_ff(pllEdge), .clampActive_ff(clampAct), .clampRedMid_ff(redMid),
        .clampBlueMid_ff(blueMid), .sogThreshold_ff(sogThr), .seekMode_ff(seek));

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clock);
        regAddr <= a;
        regWrData <= d;
        regWrEn <= 1'b1;
        @(posedge clock);
        regWrEn <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clock);
        regAddr <= a;
        regRdEn <= 1'b1;
        @(posedge clock);
        regRdEn <= 1'b0;
        #1;
        d = rdData;
    endtask

    task automatic chk8(input string what, input logic [7:0] exp, input logic [7:0] got);
        checks_done++;
        if (got !== exp) begin
            n_errors++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic chk1(input string what, input logic exp, input logic got);
        chk8(what, {7'h00, exp}, {7'h00, got});
    endtask

    task automatic idle(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask

    task automatic summarize();
        $display("checks %0d mismatches %0d", checks_done, n_errors);
        if (n_errors == 0 && checks_done > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    localparam logic [7:0] ADDRS [7] = '{8'h0E, 8'h0F, 8'h10, 8'h11, 8'h12, 8'h13, 8'h20};
    localparam logic [7:0] RSTS [7] = '{8'h40, 8'h4E, 8'h78, 8'h20, 8'h00, 8'h00, 8'h00};

    initial begin
        logic [7:0] rv;
        logic a, g, f;
        int e0, c0;
        logic hx;
        repeat (20) @(posedge clock);
        reset_n <= 1'b1;
        idle(2);
        wr(8'h20, 8'hFF);
        for (int i = 0; i < 7; i++) begin
            rd(ADDRS[i], rv);
            chk8("reset or unmapped value", RSTS[i], rv);
        end
        rd(8'h14, rv);
        chk8("detect bits idle", 8'h00, rv & 8'h92);
        chk8("slicer code", 8'h0F, {3'h0, sogThr});
        chk1("outputs driven", 1'b1, outEn);
        $display("test reset done");
        wr(8'h10, 8'hAB);
        rd(8'h10, rv);
        chk8("slicer reg", 8'hAA, rv);
        chk8("slicer out", 8'h15, {3'h0, sogThr});
        chk1("red mid", 1'b0, redMid);
        chk1("blue mid", 1'b1, blueMid);
        wr(8'h10, 8'h54);
        idle(2);
        chk8("slicer out", 8'h0A, {3'h0, sogThr});
        chk1("red mid", 1'b1, redMid);
        chk1("blue mid", 1'b0, blueMid);
        for (int i = 3; i < 6; i++) begin
            wr(ADDRS[i], 8'hA5);
            rd(ADDRS[i], rv);
            chk8("count reg", 8'hA5, rv);
            wr(ADDRS[i], RSTS[i]);
        end
        $display("test registers done");
        wr(8'h0E, 8'hD0);
        idle(8);
        a = lineOut;
        g = greenOut;
        f = frameOut;
        chk1("line out idle", 1'b0, a);
        wr(8'h0E, 8'hF4);
        idle(8);
        chk1("line out flip", ~a, lineOut);
        chk1("green out flip", ~g, greenOut);
        chk1("frame out flip", ~f, frameOut);
        wr(8'h0F, 8'h4C);
        idle(8);
        chk1("power down", 1'b0, outEn);
        wr(8'h0F, 8'h4E);
        idle(SETTLE);
        chk1("outputs driven", 1'b1, outEn);
        chk1("seek allowed", 1'b1, seek);
        wr(8'h0F, 8'h4A);
        idle(8);
        chk1("seek blocked", 1'b0, seek);
        $display("test polarity power seek done");
        for (int i = 0; i < 4; i++) begin
            wr(8'h0F, {1'b1, i[1], 6'h0E});
            clampPin <= i[0];
            idle(8);
            chk1("external clamp", i[1] ? ~i[0] : i[0], clampAct);
        end
        clampPin <= 1'b0;
        lineOn <= 1'b1;
        wr(8'h0E, 8'hD0);
        for (int i = 0; i < 2; i++) begin
            wr(8'h0F, {4'h5, i[0], 3'h6});
            coastPin <= i[0];
            idle(8);
            chk1("coast on", 1'b1, coastAct);
            e0 = edgeCount;
            idle(200);
            chk8("edges in coast", 8'h00, 8'(edgeCount - e0));
            coastPin <= ~i[0];
            idle(8);
            chk1("coast off", 1'b0, coastAct);
            e0 = edgeCount;
            c0 = clampCount;
            idle(200);
            chk1("edges resume", 1'b1, (edgeCount - e0) >= 9);
            chk1("internal clamp", 1'b1, (clampCount - c0) > 0);
        end
        wr(8'h0F, 8'h4E);
        coastPin <= 1'b0;
        $display("test clamp coast done");
        for (int k = 0; k < 8; k++) begin
            lineOn <= k[0];
            greenOn <= k[1];
            wr(8'h0E, {4'h4, k[2], 3'h0});
            idle(SETTLE);
            rd(8'h14, rv);
            hx = (k[0] != k[1]) ? k[1] : k[2];
            chk1("line detect", k[0], rv[7]);
            chk1("green detect", k[1], rv[1]);
            chk1("active line", hx, rv[6]);
        end
        for (int k = 0; k < 2; k++) begin
            lineOn <= ~k[0];
            greenOn <= k[0];
            wr(8'h0E, {4'h5, ~k[0], 3'h0});
            idle(SETTLE);
            rd(8'h14, rv);
            chk1("line override", ~k[0], rv[6]);
        end
        for (int k = 0; k < 3; k++) begin
            frameOn <= (k != 1);
            wr(8'h0E, (k == 2) ? 8'h43 : 8'h40);
            idle(SETTLE);
            rd(8'h14, rv);
            chk1("frame detect", k != 1, rv[4]);
            chk1("active frame", k != 0, rv[3]);
        end
        $display("test detect done");
        lineOn <= 1'b1;
        frameOn <= 1'b1;
        wr(8'h0E, 8'hD2);
        wr(8'h0F, 8'h6E);
        for (int k = 0; k < 3; k++) begin
            wr(8'h12, (k == 1) ? 8'h01 : 8'h00);
            wr(8'h13, (k == 2) ? 8'h02 : 8'h00);
            idle(SETTLE);
            e0 = coastCount;
            idle(640);
            if (k == 0) begin
                chk8("frame coast cycles", 8'hA0, 8'(coastCount - e0));
            end else begin
                chk1("extended coast", 1'b1, (coastCount - e0) > 160);
            end
        end
        $display("test frame coast done");
        summarize();
    end

    initial begin
        repeat (40000) @(posedge clock);
        n_errors++;
        $display("watchdog expired");
        summarize();
    end
endmodule
`default_nettype wire
